// ### rtl/adcc_pkg.sv
// Purpose: Shared constants and types of the converter control block
// Assumes: AHB-Lite word registers, byte addresses below
// Notes:   Register bits outside the converter scope read as zero
package adcc_pkg;

  // Register byte addresses
  localparam logic [7:0] ADCC_STATUS_ADDR   = 8'h0c;
  localparam logic [7:0] ADCC_PINSEL_ADDR   = 8'h20;
  localparam logic [7:0] ADCC_CTRL_ADDR     = 8'h24;
  localparam logic [7:0] ADCC_OFFCAL_ADDR   = 8'h28;
  localparam logic [7:0] ADCC_RES_HI_ADDR   = 8'h2c;
  localparam logic [7:0] ADCC_RES_NIB_ADDR  = 8'h30;
  localparam logic [7:0] ADCC_RES_LO_ADDR   = 8'h34;
  localparam logic [7:0] ADCC_IRQSTAT_ADDR  = 8'h38;

  // Field positions
  localparam int ADCC_RST_TYPE_BIT   = 7;
  localparam int ADCC_REF_SRC_BIT    = 7;
  localparam int ADCC_RATE_LSB       = 5;
  localparam int ADCC_RUN_BIT        = 4;
  localparam int ADCC_POWER_BIT      = 3;
  localparam int ADCC_TRIM_EN_BIT    = 7;
  localparam int ADCC_TRIM_SIGN_BIT  = 6;
  localparam int ADCC_TRIM_MAG_LSB   = 3;
  localparam int ADCC_REF_LVL_LSB    = 1;
  localparam int ADCC_INT_CHAN_BIT   = 0;
  localparam int ADCC_DONE_FLAG_BIT  = 5;
  localparam int ADCC_WAKE_EN_BIT    = 3;

  // Reset values
  localparam logic [7:0] ADCC_BYTE_RST = 8'h00;
  localparam logic [1:0] ADCC_RATE_RST = 2'h0;

  // Mux codes for the two internal channels
  localparam logic [3:0] ADCC_MUX_OPAMP   = 4'h8;
  localparam logic [3:0] ADCC_MUX_QUARTER = 4'h9;

  typedef enum logic [1:0] {
    ADCC_IDLE  = 2'b00,
    ADCC_START = 2'b01,
    ADCC_BUSY  = 2'b11
  } adcc_state_e;

  // Conversion clock division for each rate code
  function automatic logic [6:0] adcc_rate_div(input logic [1:0] rate);
    case (rate)
      2'h0:    adcc_rate_div = 7'h10;
      2'h1:    adcc_rate_div = 7'h04;
      2'h2:    adcc_rate_div = 7'h40;
      default: adcc_rate_div = 7'h01;
    endcase
  endfunction : adcc_rate_div

endpackage : adcc_pkg

// ### rtl/adcc_clk_if.sv
// Purpose: Carries rate, restart and tick between control and divider
// Assumes: One clock domain
// Notes:   None
interface adcc_clk_if;
  logic [1:0] rate;
  logic       restart;
  logic       tick;
  modport ctl (output rate, output restart, input tick);
  modport div (input rate, input restart, output tick);
endinterface : adcc_clk_if

// ### rtl/adcc_clkdiv.sv
// Purpose: Conversion clock divider
// Assumes: Synchronous active-high reset
// Notes:   Restart zeroes the count so the first tick is a full period later
module adcc_clkdiv
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Control
  adcc_clk_if.div  clk_ifc
);

  logic [6:0] cnt_q;
  logic [6:0] div;

  assign div         = adcc_rate_div(clk_ifc.rate);
  assign clk_ifc.tick = (cnt_q == div - 7'h01);

  always_ff @(posedge CLK) begin
    if (SYS_RST || clk_ifc.restart || clk_ifc.tick) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

endmodule : adcc_clkdiv

// ### rtl/adcc_pinmux.sv
// Purpose: Resolves the function of each shared pin
// Assumes: Oscillator and pulse enables come from elsewhere in the chip
// Notes:   Purely combinational
module adcc_pinmux
  import adcc_pkg::*;
(
  // Settings
  input  wire logic [7:0] pin_sel,
  input  wire logic       ref_src,
  input  wire logic       timer_src,
  input  wire logic       osc_out_use,
  input  wire logic       osc_in_use,
  input  wire logic       pulse1_en,
  input  wire logic       pulse2_en,
  // Resolved functions
  output logic [7:0]      pin_analog,
  output logic            pulse1_route,
  output logic            pulse2_route,
  output logic            ref_pin_analog,
  output logic            timer_clk_route
);

  always_comb begin
    pin_analog    = pin_sel;
    pin_analog[6] = pin_sel[6] & ~osc_out_use;
    pin_analog[5] = pin_sel[5] & ~osc_in_use;
  end

  assign pulse1_route    = pulse1_en & ~pin_sel[4];
  assign pulse2_route    = pulse2_en & ~pin_sel[1];
  assign ref_pin_analog  = ref_src;
  assign timer_clk_route = timer_src & ~ref_src;

endmodule : adcc_pinmux

// ### rtl/adcc_top.sv
// Purpose: Register file, sequencing and routing of the 12-bit converter
// Assumes: Single AHB-Lite master; converter core answers with a done pulse
// Notes:   Reads take one wait state, writes none
//
// Overview of operation
// - Each pin select bit: 0 keeps digital I/O, 1 makes pin analog unless the oscillator uses that pin (bits 6, 5).
// - Select bits map to port5 bit7, bit5, port7 bit0, port6 bit7, port5 bits3-0.
// - Analog input beats pulse output, which beats digital I/O.
// - Reference source 0 uses supply, 1 uses the external reference pin.
// - External reference beats timer clock input on the shared pin.
// - Rate field divides by 16, 4, 64 or 1 for codes 00 to 11.
// - Run bit set by writing 1, cleared only by hardware, resets 0.
// - Power bit 0 holds converter powered down, 1 operates.
// - Internal select picks op-amp output or quarter supply by top bit.
// - Channel bits change only while done flag and run are both low.
// - Offset trim applies only when enabled; sign 0 negative, 1 positive.
// - Offset magnitude equals twice its code in converter steps.
// - Nonzero reference level selects 4, 3, 2 volts and powers reference.
// - On completion load result, clear run, set done flag.
// - Result appears as high byte, upper nibble and low byte.
// - Reset-type bit reads 1 after pin-change, comparator or converter wake, else 0.
// - Done flag resets 0, cleared by software, never set by software.
module adcc_top
  import adcc_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Converter core
  output logic             CONV_START,
  output logic             CONV_CLK_TICK,
  output logic             CONV_POWER,
  output logic [3:0]       ANALOG_MUX_SEL,
  output logic             REF_FROM_PIN,
  output logic             INT_REF_ON,
  output logic [1:0]       INT_REF_LEVEL,
  output logic [4:0]       OFFSET_STEPS,
  output logic             OFFSET_POSITIVE,
  input  wire logic        CONV_DONE,
  input  wire logic [11:0] CONV_RESULT,
  // Pin sharing
  input  wire logic        OSC_OUT_USE,
  input  wire logic        OSC_IN_USE,
  input  wire logic        PULSE1_EN,
  input  wire logic        PULSE2_EN,
  input  wire logic        TIMER_SOURCE_SEL,
  output logic [7:0]       PIN_ANALOG,
  output logic             PULSE1_ROUTE,
  output logic             PULSE2_ROUTE,
  output logic             REF_PIN_ANALOG,
  output logic             TIMER_CLK_ROUTE,
  // Sleep and wake
  input  wire logic        SLEEP_MODE,
  input  wire logic        PIN_CHANGE_WAKE,
  input  wire logic        CMP_CHANGE_WAKE,
  input  wire logic        OTHER_WAKE,
  output logic             WAKE_REQ
);

  adcc_clk_if clk_ifc ();

  adcc_state_e state_q;
  logic        ap_wr_q;
  logic        ap_rd_q;
  logic [7:0]  ap_addr_q;
  logic        rd_done_q;
  logic [31:0] hrdata_q;
  logic [7:0]  pin_sel_q;
  logic        ref_src_q;
  logic [1:0]  rate_q;
  logic        run_q;
  logic        power_q;
  logic [2:0]  chan_q;
  logic [7:0]  offcal_q;
  logic [11:0] result_q;
  logic        done_flag_q;
  logic        wake_en_q;
  logic        rst_type_q;
  logic        wake_req_q;
  logic        addr_take;
  logic        conv_accept;
  logic [7:0]  wbyte;
  logic [7:0]  rd_byte;
  logic        wr_ctrl;
  logic        wr_offcal;
  logic        wr_irq;
  logic        wake_event;

  function automatic logic is_wr(input logic [7:0] a, input logic [7:0] r,
                                 input logic wr);
    is_wr = wr && (a == r);
  endfunction : is_wr

  // Bus address phase
  assign addr_take = HSEL && HTRANS[1] && HREADY;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ap_wr_q   <= 1'b0;
      ap_rd_q   <= 1'b0;
      ap_addr_q <= 8'h00;
    end else if (HREADYOUT) begin
      ap_wr_q   <= addr_take && HWRITE;
      ap_rd_q   <= addr_take && !HWRITE;
      ap_addr_q <= HADDR[7:0];
    end
  end

  // Read wait state so that read data leaves a flip-flop
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rd_done_q <= 1'b0;
      hrdata_q  <= 32'h0000_0000;
    end else begin
      rd_done_q <= ap_rd_q && !rd_done_q;
      if (ap_rd_q && !rd_done_q) begin
        hrdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign HREADYOUT = !(ap_rd_q && !rd_done_q);
  assign HRDATA    = hrdata_q;
  assign HRESP     = 1'b0;

  assign wbyte     = HWDATA[7:0];
  assign wr_ctrl   = is_wr(ap_addr_q, ADCC_CTRL_ADDR, ap_wr_q);
  assign wr_offcal = is_wr(ap_addr_q, ADCC_OFFCAL_ADDR, ap_wr_q);
  assign wr_irq    = is_wr(ap_addr_q, ADCC_IRQSTAT_ADDR, ap_wr_q);

  always_comb begin
    case (ap_addr_q)
      ADCC_STATUS_ADDR:  rd_byte = {rst_type_q, 7'h00};
      ADCC_PINSEL_ADDR:  rd_byte = pin_sel_q;
      ADCC_CTRL_ADDR:    rd_byte = {ref_src_q, rate_q, run_q, power_q, chan_q};
      ADCC_OFFCAL_ADDR:  rd_byte = offcal_q;
      ADCC_RES_HI_ADDR:  rd_byte = result_q[11:4];
      ADCC_RES_NIB_ADDR: rd_byte = {4'h0, result_q[11:8]};
      ADCC_RES_LO_ADDR:  rd_byte = result_q[7:0];
      ADCC_IRQSTAT_ADDR: rd_byte = {2'h0, done_flag_q, 1'b0, wake_en_q, 3'h0};
      default:           rd_byte = 8'h00;
    endcase
  end

  // Plain configuration registers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pin_sel_q <= ADCC_BYTE_RST;
      ref_src_q <= 1'b0;
      rate_q    <= ADCC_RATE_RST;
      power_q   <= 1'b0;
      offcal_q  <= ADCC_BYTE_RST;
      wake_en_q <= 1'b0;
    end else begin
      if (is_wr(ap_addr_q, ADCC_PINSEL_ADDR, ap_wr_q)) begin
        pin_sel_q <= wbyte;
      end
      if (wr_ctrl) begin
        ref_src_q <= wbyte[ADCC_REF_SRC_BIT];
        rate_q    <= wbyte[ADCC_RATE_LSB +: 2];
        power_q   <= wbyte[ADCC_POWER_BIT];
      end
      if (wr_offcal) begin
        offcal_q <= wbyte;
      end
      if (wr_irq) begin
        wake_en_q <= wbyte[ADCC_WAKE_EN_BIT];
      end
    end
  end

  // Channel bits frozen while a result is pending or running
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      chan_q <= 3'h0;
    end else if (wr_ctrl && !done_flag_q && !run_q) begin
      chan_q <= wbyte[2:0];
    end
  end

  // Run bit: software sets, hardware clears; a start write wins
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      run_q <= 1'b0;
    end else if (wr_ctrl && wbyte[ADCC_RUN_BIT]) begin
      run_q <= 1'b1;
    end else if (conv_accept) begin
      run_q <= 1'b0;
    end
  end

  // Conversion sequencer
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_q <= ADCC_IDLE;
    end else begin
      case (state_q)
        ADCC_IDLE:  if (run_q) state_q <= ADCC_START;
        ADCC_START: state_q <= ADCC_BUSY;
        ADCC_BUSY:  if (CONV_DONE) state_q <= ADCC_IDLE;
        default:    state_q <= ADCC_IDLE;
      endcase
    end
  end

  assign conv_accept = (state_q == ADCC_BUSY) && CONV_DONE;
  assign CONV_START  = (state_q == ADCC_START);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      result_q <= 12'h000;
    end else if (conv_accept) begin
      result_q <= CONV_RESULT;
    end
  end

  // Done flag: hardware set beats software clear
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      done_flag_q <= 1'b0;
    end else if (conv_accept) begin
      done_flag_q <= 1'b1;
    end else if (wr_irq && !wbyte[ADCC_DONE_FLAG_BIT]) begin
      done_flag_q <= 1'b0;
    end
  end

  // Wake and reset type; converter wakes only when enabled by software
  assign wake_event = SLEEP_MODE &&
                      (PIN_CHANGE_WAKE || CMP_CHANGE_WAKE || (conv_accept && wake_en_q));

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rst_type_q <= 1'b0;
      wake_req_q <= 1'b0;
    end else begin
      wake_req_q <= wake_event;
      if (wake_event) begin
        rst_type_q <= 1'b1;
      end else if (OTHER_WAKE) begin
        rst_type_q <= 1'b0;
      end
    end
  end

  assign WAKE_REQ = wake_req_q;

  // Conversion clock
  assign clk_ifc.rate    = rate_q;
  assign clk_ifc.restart = CONV_START;
  assign CONV_CLK_TICK   = clk_ifc.tick && power_q;

  adcc_clkdiv u_clkdiv (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .clk_ifc (clk_ifc)
  );

  // Converter settings
  assign CONV_POWER      = power_q;
  assign ANALOG_MUX_SEL  = !offcal_q[ADCC_INT_CHAN_BIT] ? {1'b0, chan_q} :
                           (chan_q[2] ? ADCC_MUX_QUARTER : ADCC_MUX_OPAMP);
  assign REF_FROM_PIN    = ref_src_q;
  assign INT_REF_LEVEL   = offcal_q[ADCC_REF_LVL_LSB +: 2];
  assign INT_REF_ON      = (INT_REF_LEVEL != 2'h0);
  assign OFFSET_STEPS    = offcal_q[ADCC_TRIM_EN_BIT] ?
                           {1'b0, offcal_q[ADCC_TRIM_MAG_LSB +: 3], 1'b0} : 5'h00;
  assign OFFSET_POSITIVE = offcal_q[ADCC_TRIM_EN_BIT] && offcal_q[ADCC_TRIM_SIGN_BIT];

  adcc_pinmux u_pinmux (
    .pin_sel         (pin_sel_q),
    .ref_src         (ref_src_q),
    .timer_src       (TIMER_SOURCE_SEL),
    .osc_out_use     (OSC_OUT_USE),
    .osc_in_use      (OSC_IN_USE),
    .pulse1_en       (PULSE1_EN),
    .pulse2_en       (PULSE2_EN),
    .pin_analog      (PIN_ANALOG),
    .pulse1_route    (PULSE1_ROUTE),
    .pulse2_route    (PULSE2_ROUTE),
    .ref_pin_analog  (REF_PIN_ANALOG),
    .timer_clk_route (TIMER_CLK_ROUTE)
  );

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  property p_run_no_sw_clear;
    run_q && !conv_accept |=> run_q;
  endproperty
  a_run_no_sw_clear: assert property (p_run_no_sw_clear) else $error("run cleared early");

  // A start write in the completion cycle keeps run set
  property p_done_load;
    conv_accept |=> result_q == $past(CONV_RESULT) && done_flag_q &&
                    (!run_q || $past(wr_ctrl && wbyte[ADCC_RUN_BIT]));
  endproperty
  a_done_load: assert property (p_done_load) else $error("completion not recorded");

  property p_chan_hold;
    done_flag_q || run_q |=> chan_q == $past(chan_q);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel changed while busy");

  property p_internal_mux;
    offcal_q[ADCC_INT_CHAN_BIT] && chan_q[2] |-> ANALOG_MUX_SEL == ADCC_MUX_QUARTER;
  endproperty
  a_internal_mux: assert property (p_internal_mux) else $error("bad internal channel");

  property p_ref_priority;
    TIMER_CLK_ROUTE |-> !REF_PIN_ANALOG && !ref_src_q;
  endproperty
  a_ref_priority: assert property (p_ref_priority) else $error("timer beat reference");

  property p_trim_off;
    !offcal_q[ADCC_TRIM_EN_BIT] |-> OFFSET_STEPS == 5'h00 && !OFFSET_POSITIVE;
  endproperty
  a_trim_off: assert property (p_trim_off) else $error("trim applied while off");

  property p_start_follows_run;
    $rose(run_q) |=> CONV_START;
  endproperty
  a_start_follows_run: assert property (p_start_follows_run) else $error("no start");

  property p_flag_set_wins;
    conv_accept |=> done_flag_q;
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) else $error("done flag lost");

  property p_power_gate;
    !power_q |-> !CONV_POWER && !CONV_CLK_TICK;
  endproperty
  a_power_gate: assert property (p_power_gate) else $error("converter not held down");

  property p_div_restart;
    CONV_START && rate_q == 2'h1 && power_q ##1 ($stable(rate_q) && power_q) [*4]
      |-> !$past(CONV_CLK_TICK, 3) && CONV_CLK_TICK;
  endproperty
  a_div_restart: assert property (p_div_restart) else $error("divider not restarted");

  c_conversion: cover property (CONV_START ##[1:100] conv_accept);
  c_wake:       cover property (wake_req_q && rst_type_q);
  c_chan_block: cover property (wr_ctrl && done_flag_q);

endmodule : adcc_top

// ### verif/adcc_core_model.sv
// Purpose: Behavioural model of the analog converter core
// Assumes: Start pulse, then a fixed number of powered conversion ticks
// Notes:   Result bus shows the inverse of the last value outside done
module adcc_core_model #(
  parameter int TICKS = 40
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Control from the block
  input  wire logic        conv_start,
  input  wire logic        conv_clk_tick,
  input  wire logic        conv_power,
  // Result handshake
  input  wire logic [11:0] next_result,
  output logic             conv_done,
  output logic [11:0]      conv_result
);
  timeunit 1ns;
  timeprecision 1ps;

  int          cnt;
  logic        busy;
  logic [11:0] last;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy      <= 1'h0;
      cnt       <= 0;
      conv_done <= 1'h0;
      last      <= 12'h000;
    end else begin
      conv_done <= 1'h0;
      if (conv_start) begin
        busy <= 1'h1;
        cnt  <= 0;
      end else if (busy && conv_power && conv_clk_tick) begin
        cnt <= cnt + 1;
        if (cnt == TICKS - 1) begin
          busy      <= 1'h0;
          conv_done <= 1'h1;
          last      <= next_result;
        end
      end
    end
  end

  // Stale data must not pass for a fresh result
  assign conv_result = conv_done ? last : ~last;
endmodule : adcc_core_model

// ### verif/adcc_top_tb.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: One AHB-Lite master; core model answers after 40 ticks
// Notes:   Start-to-tick spacing is measured on sampled edges
module adcc_top_tb;
  import adcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        hsel = 1'h0;
  logic        hwrite = 1'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rdv;
  logic        hready, hresp, start, tick, power, done, ref_pin, iref_on, pos, wake_req;
  logic        p1_rt, p2_rt, ref_an, tmr_rt;
  logic [3:0]  mux;
  logic [1:0]  lvl;
  logic [4:0]  steps;
  logic [7:0]  pin_an;
  logic [11:0] result;
  logic [11:0] next_res = 12'h0;
  logic [3:0]  pinctl = 4'h0;
  logic        tmr_src = 1'h0;
  logic        sleep = 1'h0;
  logic [2:0]  wk = 3'h0;
  logic [7:0]  irqx = 8'h0;
  int          fails = 0;
  int          compares = 0;
  int          div [4] = '{16, 4, 64, 1};
  logic [7:0]  adr [9] = '{ADCC_STATUS_ADDR, ADCC_PINSEL_ADDR, ADCC_CTRL_ADDR,
    ADCC_OFFCAL_ADDR, ADCC_RES_HI_ADDR, ADCC_RES_NIB_ADDR, ADCC_RES_LO_ADDR,
    ADCC_IRQSTAT_ADDR, 8'h40};
  // Pin select, {osc out, osc in, pulse1, pulse2}, {analog pins, routes}
  logic [21:0] pt [6] = '{{8'hff, 4'h0, 10'h3fc}, {8'hff, 4'h8, 10'h2fc},
    {8'hff, 4'h4, 10'h37c}, {8'hef, 4'h3, 10'h3be}, {8'hfd, 4'h3, 10'h3f5},
    {8'h00, 4'h3, 10'h003}};

  always #2 clk = ~clk;

  adcc_top adcc_top_i (
    .CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .CONV_START(start), .CONV_CLK_TICK(tick),
    .CONV_POWER(power), .ANALOG_MUX_SEL(mux), .REF_FROM_PIN(ref_pin),
    .INT_REF_ON(iref_on), .INT_REF_LEVEL(lvl), .OFFSET_STEPS(steps),
    .OFFSET_POSITIVE(pos), .CONV_DONE(done), .CONV_RESULT(result),
    .OSC_OUT_USE(pinctl[3]), .OSC_IN_USE(pinctl[2]), .PULSE1_EN(pinctl[1]),
    .PULSE2_EN(pinctl[0]), .TIMER_SOURCE_SEL(tmr_src), .PIN_ANALOG(pin_an),
    .PULSE1_ROUTE(p1_rt), .PULSE2_ROUTE(p2_rt), .REF_PIN_ANALOG(ref_an),
    .TIMER_CLK_ROUTE(tmr_rt), .SLEEP_MODE(sleep), .PIN_CHANGE_WAKE(wk[0]),
    .CMP_CHANGE_WAKE(wk[1]), .OTHER_WAKE(wk[2]), .WAKE_REQ(wake_req));

  adcc_core_model #(.TICKS(40)) adcc_core_model_i (
    .clk(clk), .sys_rst(rst), .conv_start(start), .conv_clk_tick(tick),
    .conv_power(power), .next_result(next_res), .conv_done(done), .conv_result(result));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // Slave may stretch the phase; bounded so a hang ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do @(posedge clk); while (hready !== 1'h1 && ++n < 20);
    if (hready !== 1'h1) begin
      fails++;
      end_sim();
    end
  endtask : wait_rdy

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] v);
    @(posedge clk);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel   <= 1'h0;
    hwdata <= {24'h0, v};
    wait_rdy();
    rdv = hrdata;
    #1;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus(a, 1'h1, v);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(a, 1'h0, 8'h0);
    chk(rdv | {hresp, 31'h0}, {24'h0, e});
  endtask : rdc

  task automatic conv(input logic [1:0] r, input logic [11:0] res, input logic late);
    int n;
    logic [7:0] c;
    c = {1'h0, r, 1'h1, ~late, 3'h5};
    @(posedge clk) next_res <= res;
    wr(ADCC_CTRL_ADDR, c);
    n = 0;
    if (late) begin
      repeat (150) begin
        @(posedge clk);
        n += (tick === 1'h1);
      end
      chk({n[7:0], power}, 9'h0);
      c[3] = 1'h1;
      wr(ADCC_CTRL_ADDR, c);
    end else begin
      do @(posedge clk); while (start !== 1'h1 && ++n < 10);
      chk(start, 1'h1);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (tick !== 1'h1 && n < 99);
      chk(n, div[r]);
    end
    wr(ADCC_CTRL_ADDR, c & 8'he8);
    rdc(ADCC_CTRL_ADDR, c);
    n = 0;
    do @(posedge clk); while (done !== 1'h1 && ++n < 3000);
    if (n >= 3000) begin
      fails++;
      end_sim();
    end
    rdc(ADCC_CTRL_ADDR, c & 8'hef);
    rdc(ADCC_RES_HI_ADDR, res[11:4]);
    rdc(ADCC_RES_NIB_ADDR, {4'h0, res[11:8]});
    rdc(ADCC_RES_LO_ADDR, res[7:0]);
    rdc(ADCC_IRQSTAT_ADDR, irqx | 8'h20);
    wr(ADCC_CTRL_ADDR, c & 8'he8);
    rdc(ADCC_CTRL_ADDR, c & 8'hef);
    wr(ADCC_IRQSTAT_ADDR, irqx | 8'h20);
    rdc(ADCC_IRQSTAT_ADDR, irqx | 8'h20);
    wr(ADCC_IRQSTAT_ADDR, irqx);
    wr(ADCC_IRQSTAT_ADDR, irqx | 8'h20);
    rdc(ADCC_IRQSTAT_ADDR, irqx);
    wr(ADCC_CTRL_ADDR, c & 8'he8);
    rdc(ADCC_CTRL_ADDR, c & 8'he8);
  endtask : conv

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    foreach (adr[i]) rdc(adr[i], 8'h00);
    foreach (pt[i]) begin
      @(posedge clk) pinctl <= pt[i][13:10];
      wr(ADCC_PINSEL_ADDR, pt[i][21:14]);
      chk({pin_an, p1_rt, p2_rt}, pt[i][9:0]);
    end
    rdc(ADCC_PINSEL_ADDR, 8'h00);
    @(posedge clk) tmr_src <= 1'h1;
    wr(ADCC_CTRL_ADDR, 8'h80);
    chk({ref_pin, ref_an, tmr_rt}, 3'h6);
    wr(ADCC_CTRL_ADDR, 8'h00);
    chk({ref_pin, ref_an, tmr_rt}, 3'h1);
    for (int c = 0; c < 8; c++) begin
      wr(ADCC_OFFCAL_ADDR, 8'h00);
      wr(ADCC_CTRL_ADDR, c[7:0]);
      chk(mux, c);
      wr(ADCC_OFFCAL_ADDR, 8'h01);
      chk(mux, {3'h4, c[2]});
    end
    for (int m = 0; m < 8; m++) begin
      wr(ADCC_OFFCAL_ADDR, {1'h1, m[0], m[2:0], m[1:0], 1'h0});
      chk({steps, pos, iref_on, lvl}, {m[3:0], 1'h0, m[0], |m[1:0], m[1:0]});
    end
    wr(ADCC_OFFCAL_ADDR, 8'h78);
    chk({steps, pos, iref_on, lvl}, 9'h0);
    wr(ADCC_OFFCAL_ADDR, 8'h02);
    repeat (12500) @(posedge clk);
    conv(2'h0, 12'hb7c, 1'h0);
    conv(2'h1, 12'h4e1, 1'h0);
    conv(2'h2, 12'h0f3, 1'h0);
    irqx = 8'h08;
    wr(ADCC_IRQSTAT_ADDR, irqx);
    @(posedge clk) sleep <= 1'h1;
    conv(2'h3, 12'h96a, 1'h0);
    rdc(ADCC_STATUS_ADDR, 8'h80);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) wk <= 3'h4;
      @(posedge clk) wk <= 3'h0;
      #1 chk(wake_req, 1'h0);
      rdc(ADCC_STATUS_ADDR, 8'h00);
      @(posedge clk) wk <= 3'h1 << i;
      @(posedge clk) wk <= 3'h0;
      #1 chk(wake_req, 1'h1);
      rdc(ADCC_STATUS_ADDR, 8'h80);
    end
    @(posedge clk) sleep <= 1'h0;
    conv(2'h1, 12'h5a6, 1'h1);
    end_sim();
  end
endmodule : adcc_top_tb
